// ---- design/tws_slave.sv ----
// Two-wire serial register slave with its register memory
module tws_slave (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic upd_valid,
	input wire logic [7:0] upd_addr,
	input wire logic [7:0] upd_data,
	output logic upd_ready,
	output logic hw_valid,
	output logic [7:0] hw_addr,
	output logic [7:0] hw_data
);
	import tws_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Address decoding
	function automatic logic writable(input logic [7:0] a);
		writable = (a == CFG_ADDR) || (a == ACC_MSB_ADDR) ||
			(a == ACC_LSB_ADDR) || (a == OFS_BIAS_ADDR) ||
			(a == ACC_BIAS_ADDR);
	endfunction

	function automatic logic pair_msb(input logic [7:0] a);
		pair_msb = (a >= PAIR_FIRST) && (a <= PAIR_LAST) && !a[0];
	endfunction

	function automatic logic [8:0] ptr_inc(input logic [8:0] p);
		ptr_inc = p[8] ? p : p + 9'h001;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin sampling
	logic [2:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic ce_l;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	tws_sync #(.W(3)) u_pin_sync (
		.clk(link_clk),
		.rst_n(rst_n),
		.din({scl_in, sda_in, ce}),
		.dout(pin_s)
	);

	assign scl_s = pin_s[2];
	assign sda_s = pin_s[1];
	assign ce_l = pin_s[0];

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_l) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign start_ev = scl_s && scl_q && sda_q && !sda_s;
	assign stop_ev = scl_s && scl_q && !sda_q && sda_s;

	////////////////////////////////////////////////////////////////////////
	// Register memory
	logic [7:0] mem [0:255];
	logic upd_fire;
	logic [XFER_W-1:0] upd_word;
	logic wr_fire;
	logic [7:0] pend_addr;
	logic [7:0] pend_data;

	tws_xfer u_upd_xfer (
		.src_clk(clk),
		.src_rst_n(rst_n),
		.src_ce(ce),
		.src_valid(upd_valid),
		.src_data({upd_addr, upd_data}),
		.src_ready(upd_ready),
		.dst_clk(link_clk),
		.dst_rst_n(rst_n),
		.dst_ce(ce_l),
		.dst_valid(upd_fire),
		.dst_data(upd_word)
	);

	tws_xfer u_wr_xfer (
		.src_clk(link_clk),
		.src_rst_n(rst_n),
		.src_ce(ce_l),
		.src_valid(wr_fire),
		.src_data({pend_addr, pend_data}),
		.src_ready(),
		.dst_clk(clk),
		.dst_rst_n(rst_n),
		.dst_ce(ce),
		.dst_valid(hw_valid),
		.dst_data({hw_addr, hw_data})
	);

	always_ff @(posedge link_clk) begin
		if (ce_l) begin
			if (wr_fire) begin
				mem[pend_addr] <= pend_data;
			end else if (upd_fire) begin
				mem[upd_word[15:8]] <= upd_word[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protocol engine
	tws_state_e st;
	tws_state_e next_st;
	tws_kind_e kind;
	tws_kind_e next_kind;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [7:0] sr;
	logic [7:0] next_sr;
	logic [7:0] tx_sr;
	logic [7:0] next_tx_sr;
	logic [8:0] ptr;
	logic [8:0] next_ptr;
	logic rw;
	logic next_rw;
	logic nak;
	logic next_nak;
	logic past_lim;
	logic next_past_lim;
	logic wr_ok;
	logic next_wr_ok;
	logic [7:0] next_pend_addr;
	logic [7:0] next_pend_data;
	logic next_oe;
	logic hold_valid;
	logic next_hold_valid;
	logic [7:0] hold_addr;
	logic [7:0] next_hold_addr;
	logic [7:0] hold_data;
	logic [7:0] next_hold_data;
	logic [7:0] rd_byte;
	logic load;

	assign sda_out = 1'b0;

	always_comb begin
		if (ptr[8]) begin
			rd_byte = OVER_READ_DATA;
		end else if (hold_valid && ptr[7:0] == hold_addr) begin
			rd_byte = hold_data;
		end else begin
			rd_byte = mem[ptr[7:0]];
		end
	end

	always_comb begin
		next_st = st;
		next_kind = kind;
		next_bitcnt = bitcnt;
		next_sr = sr;
		next_tx_sr = tx_sr;
		next_ptr = ptr;
		next_rw = rw;
		next_nak = nak;
		next_past_lim = past_lim;
		next_wr_ok = wr_ok;
		next_pend_addr = pend_addr;
		next_pend_data = pend_data;
		next_oe = sda_oe;
		next_hold_valid = hold_valid;
		next_hold_addr = hold_addr;
		next_hold_data = hold_data;
		wr_fire = 1'b0;
		load = 1'b0;
		if (stop_ev) begin
			next_st = ST_IDLE;
			next_oe = 1'b0;
			next_hold_valid = 1'b0;
		end else if (start_ev) begin
			next_st = ST_RECV;
			next_kind = K_ADDR;
			next_bitcnt = 4'h0;
			next_oe = 1'b0;
			next_hold_valid = 1'b0;
		end else begin
			case (st)
				ST_IDLE: begin
					next_oe = 1'b0;
				end
				ST_RECV: begin
					if (scl_rise && bitcnt < BYTE_BITS) begin
						next_sr = {sr[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == BYTE_BITS) begin
						next_st = ST_ACK;
						next_oe = 1'b1;
						case (kind)
							K_ADDR: begin
								next_rw = sr[0];
								if (sr[7:1] != DEVICE_BUS_ADDRESS) begin
									next_st = ST_IDLE;
									next_oe = 1'b0;
								end
							end
							K_PTR: begin
								next_ptr = {1'b0, sr};
								next_past_lim = 1'b0;
							end
							K_DATA: begin
								next_pend_addr = ptr[7:0];
								next_pend_data = sr;
								next_wr_ok = !ptr[8] && !past_lim &&
									writable(ptr[7:0]);
								next_ptr = ptr_inc(ptr);
								if (ptr[7:0] == LAST_WR_ADDR || ptr[8]) begin
									next_past_lim = 1'b1;
								end
							end
							default: begin
								next_st = ST_IDLE;
								next_oe = 1'b0;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						next_oe = 1'b0;
						next_bitcnt = 4'h0;
						if (kind == K_DATA && wr_ok) begin
							wr_fire = 1'b1;
						end
						if (kind == K_ADDR && rw) begin
							next_st = ST_TX;
							load = 1'b1;
						end else begin
							next_st = ST_RECV;
							next_kind = (kind == K_ADDR) ? K_PTR : K_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bitcnt == BYTE_BITS - 4'h1) begin
							next_st = ST_MACK;
							next_oe = 1'b0;
							next_ptr = ptr_inc(ptr);
						end else begin
							next_bitcnt = bitcnt + 4'h1;
							next_tx_sr = {tx_sr[6:0], 1'b0};
							next_oe = !tx_sr[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						next_nak = sda_s;
					end else if (scl_fall) begin
						next_bitcnt = 4'h0;
						if (nak) begin
							next_st = ST_IDLE;
						end else begin
							next_st = ST_TX;
							load = 1'b1;
						end
					end
				end
				default: begin
					next_st = ST_IDLE;
					next_oe = 1'b0;
				end
			endcase
		end
		if (load) begin
			next_tx_sr = rd_byte;
			next_oe = !rd_byte[7];
			if (!ptr[8] && pair_msb(ptr[7:0])) begin
				next_hold_valid = 1'b1;
				next_hold_addr = ptr[7:0] + 8'h01;
				next_hold_data = mem[ptr[7:0] + 8'h01];
			end
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			kind <= K_ADDR;
			bitcnt <= 4'h0;
			sr <= 8'h00;
			tx_sr <= 8'h00;
			ptr <= 9'h000;
			rw <= 1'b0;
			nak <= 1'b0;
			past_lim <= 1'b0;
			wr_ok <= 1'b0;
			pend_addr <= 8'h00;
			pend_data <= 8'h00;
			sda_oe <= 1'b0;
			hold_valid <= 1'b0;
			hold_addr <= 8'h00;
			hold_data <= 8'h00;
		end else if (ce_l) begin
			st <= next_st;
			kind <= next_kind;
			bitcnt <= next_bitcnt;
			sr <= next_sr;
			tx_sr <= next_tx_sr;
			ptr <= next_ptr;
			rw <= next_rw;
			nak <= next_nak;
			past_lim <= next_past_lim;
			wr_ok <= next_wr_ok;
			pend_addr <= next_pend_addr;
			pend_data <= next_pend_data;
			sda_oe <= next_oe;
			hold_valid <= next_hold_valid;
			hold_addr <= next_hold_addr;
			hold_data <= next_hold_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic addr_end;
	assign addr_end = ce_l && !start_ev && !stop_ev && st == ST_RECV &&
		scl_fall && bitcnt == BYTE_BITS && kind == K_ADDR;
	logic data_end;
	assign data_end = ce_l && !start_ev && !stop_ev && st == ST_RECV &&
		scl_fall && bitcnt == BYTE_BITS && kind == K_DATA;

	addr_ack_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(addr_end && sr[7:1] == DEVICE_BUS_ADDRESS) |=>
		sda_oe && st == ST_ACK)
		else $error("matching address not acknowledged");
	addr_nak_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(addr_end && sr[7:1] != DEVICE_BUS_ADDRESS) |=>
		!sda_oe && st == ST_IDLE)
		else $error("foreign address acknowledged");
	ack_hold_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(st == ST_ACK && ce_l && !scl_fall && !start_ev && !stop_ev)
		|=> sda_oe)
		else $error("ack released before clock fell");
	high_stable_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(ce_l && scl_s && scl_q && !start_ev && !stop_ev)
		|=> $stable(sda_oe))
		else $error("data line moved while clock high");
	stop_release_a: assert property (@(posedge link_clk)
		disable iff (!rst_n)
		(ce_l && stop_ev) |=> st == ST_IDLE && !sda_oe)
		else $error("line held after stop");
	start_addr_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(ce_l && start_ev) |=> st == ST_RECV && kind == K_ADDR &&
		bitcnt == 4'h0)
		else $error("start did not begin address byte");
	over_read_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(ce_l && load && ptr[8]) |=> tx_sr == 8'hFF)
		else $error("read past end not FFh");
	limit_write_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(data_end && (past_lim || ptr[8])) |=> !wr_ok)
		else $error("write after limit stored");
	commit_ack_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		wr_fire |-> sda_oe && st == ST_ACK && writable(pend_addr))
		else $error("store outside owned ack");
	mack_free_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		st == ST_MACK |-> !sda_oe)
		else $error("drove line in master ack");
	tx_inc_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		(st == ST_TX && next_st == ST_MACK && ce_l && !ptr[8])
		|=> ptr == $past(ptr) + 9'h001)
		else $error("pointer not advanced after sent byte");

	addr_ack_c: cover property (@(posedge link_clk) disable iff (!rst_n)
		addr_end && sr[7:1] == DEVICE_BUS_ADDRESS);
	write_c: cover property (@(posedge link_clk) disable iff (!rst_n)
		wr_fire);
	read_more_c: cover property (@(posedge link_clk) disable iff (!rst_n)
		st == ST_MACK && load);
	stop_c: cover property (@(posedge link_clk) disable iff (!rst_n)
		ce_l && stop_ev && st == ST_IDLE);
endmodule // tws_slave

// ---- design/tws_pkg.sv ----
// Shared constants and types for the two-wire register slave
package tws_pkg;
	// Fixed bus address of the device
	localparam logic [6:0] DEVICE_BUS_ADDRESS = 7'h36;
	// Bits in one byte on the wire
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Last address an auto-incremented write started at or below it may reach
	localparam logic [7:0] LAST_WR_ADDR = 8'h4F;
	// Function command location
	localparam logic [7:0] FUNCTION_COMMAND_BYTE = 8'hFE;
	// Data returned past the end of memory
	localparam logic [7:0] OVER_READ_DATA = 8'hFF;
	// Writable register locations
	localparam logic [7:0] CFG_ADDR = 8'h01;
	localparam logic [7:0] ACC_MSB_ADDR = 8'h10;
	localparam logic [7:0] ACC_LSB_ADDR = 8'h11;
	localparam logic [7:0] OFS_BIAS_ADDR = 8'h61;
	localparam logic [7:0] ACC_BIAS_ADDR = 8'h62;
	// Span of two-byte registers, most significant byte at even address
	localparam logic [7:0] PAIR_FIRST = 8'h08;
	localparam logic [7:0] PAIR_LAST = 8'h11;
	// Width of address plus data word crossing domains
	localparam int XFER_W = 16;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_ACK,
		ST_TX,
		ST_MACK
	} tws_state_e;

	typedef enum logic [1:0] {
		K_ADDR,
		K_PTR,
		K_DATA
	} tws_kind_e;
endpackage : tws_pkg

// ---- design/tws_sync.sv ----
// Two flip-flop level synchroniser
module tws_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	import tws_pkg::*;

	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_dout;

	always_comb begin
		next_stage1 = din;
		next_dout = stage1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= next_stage1;
			dout <= next_dout;
		end
	end
endmodule // tws_sync

// ---- design/tws_xfer.sv ----
// Toggle handshake carrying one word between clock domains
module tws_xfer (
	input wire logic src_clk,
	input wire logic src_rst_n,
	input wire logic src_ce,
	input wire logic src_valid,
	input wire logic [tws_pkg::XFER_W-1:0] src_data,
	output logic src_ready,
	input wire logic dst_clk,
	input wire logic dst_rst_n,
	input wire logic dst_ce,
	output logic dst_valid,
	output logic [tws_pkg::XFER_W-1:0] dst_data
);
	import tws_pkg::*;

	logic req;
	logic next_req;
	logic [XFER_W-1:0] hold;
	logic [XFER_W-1:0] next_hold;
	logic ack_s;
	logic req_s;
	logic seen;
	logic next_valid;
	logic [XFER_W-1:0] next_dst_data;

	////////////////////////////////////////////////////////////////////////
	// Source side
	assign src_ready = (req == ack_s);

	always_comb begin
		next_req = req;
		next_hold = hold;
		if (src_valid && src_ready) begin
			next_req = ~req;
			next_hold = src_data;
		end
	end

	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			req <= 1'b0;
			hold <= '0;
		end else if (src_ce) begin
			req <= next_req;
			hold <= next_hold;
		end
	end

	tws_sync #(.W(1)) u_ack_sync (
		.clk(src_clk),
		.rst_n(src_rst_n),
		.din(seen),
		.dout(ack_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Destination side
	tws_sync #(.W(1)) u_req_sync (
		.clk(dst_clk),
		.rst_n(dst_rst_n),
		.din(req),
		.dout(req_s)
	);

	always_comb begin
		next_valid = (req_s != seen);
		next_dst_data = next_valid ? hold : dst_data;
	end

	always_ff @(posedge dst_clk or negedge dst_rst_n) begin
		if (!dst_rst_n) begin
			seen <= 1'b0;
			dst_valid <= 1'b0;
			dst_data <= '0;
		end else if (dst_ce) begin
			seen <= req_s;
			dst_valid <= next_valid;
			dst_data <= next_dst_data;
		end
	end
endmodule // tws_xfer

// ---- dv/tws_master_model.sv ----
// Bus master model for the two-wire link, with a pull-up on the data line
module tws_master_model (
	input wire logic dev_oe,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pull_low;
	int half_ns;
	////////////////////////////////////////////////////////////////////////
	// Wired-and data line; released means high
	assign sda = !(pull_low || dev_oe);
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
		half_ns = 1300;
	end
	// One bit: data set in the low phase, held while the clock is high
	task automatic bit_cyc(input logic b, output logic s);
		#200 pull_low = !b;
		#(half_ns - 200) scl = 1'b1;
		#(half_ns) s = sda;
		scl = 1'b0;
	endtask
	// Start, or repeated start when the clock is low
	task automatic m_start;
		if (scl === 1'b0) begin
			#200 pull_low = 1'b0;
			#(half_ns - 200) scl = 1'b1;
			#(half_ns);
		end
		pull_low = 1'b1;
		#(half_ns) scl = 1'b0;
	endtask
	task automatic m_stop;
		#200 pull_low = 1'b1;
		#(half_ns - 200) scl = 1'b1;
		#(half_ns) pull_low = 1'b0;
		#(half_ns);
	endtask
	// Byte out msb first; ack is a low data line on the ninth pulse
	task automatic m_wr(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(b[i], s);
		end
		bit_cyc(1'b1, s);
		ack = !s;
	endtask
	task automatic m_rd(input logic give_ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'b1, s);
			b[i] = s;
		end
		bit_cyc(!give_ack, s);
	endtask
	// Breaks a byte off after n bits, then stops
	task automatic m_abort(input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			bit_cyc(i[0], s);
		end
		m_stop;
	endtask
endmodule // tws_master_model

// ---- dv/test_two_wire_register_slave.sv ----
// Self-checking bench for the two-wire register slave
module test_two_wire_register_slave;
	timeunit 1ns;
	timeprecision 1ps;
	import tws_pkg::*;
	logic clk, rst_n, link_clk, scl, sda, sda_oe, sda_out, ack;
	logic upd_valid, upd_ready, hw_valid;
	logic [7:0] upd_addr, upd_data, hw_addr, hw_data;
	logic [15:0] hw_q[$];
	logic [23:0] rd;
	int error_cnt, checks_done, cycles;
	////////////////////////////////////////////////////////////////////////
	tws_slave tws_slave_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.link_clk(link_clk), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .upd_valid(upd_valid),
		.upd_addr(upd_addr), .upd_data(upd_data), .upd_ready(upd_ready),
		.hw_valid(hw_valid), .hw_addr(hw_addr), .hw_data(hw_data));
	tws_master_model tws_master_model_i (.dev_oe(sda_oe), .scl(scl),
		.sda(sda));
	always #12.5 clk = !clk;
	always #80 link_clk = !link_clk;
	////////////////////////////////////////////////////////////////////////
	// Store monitor and timeout
	always @(negedge clk) begin
		cycles <= cycles + 1;
		if (hw_valid === 1'b1) begin
			hw_q.push_back({hw_addr, hw_data});
		end
		if (cycles == 90000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	always @(sda_oe) begin
		if (rst_n === 1'b1 && scl === 1'b1) begin
			error_cnt++;
			$display("MISMATCH sda_oe edge with clock high expected 0 seen 1");
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_ck(input logic [7:0] b);
		tws_master_model_i.m_wr(b, ack);
		check("byte ack", 24'h1, {23'h0, ack});
	endtask
	task automatic upd_write(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk);
		upd_valid = 1'b1;
		upd_addr = a;
		upd_data = d;
		while (upd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		upd_valid = 1'b0;
	endtask
	task automatic write_two(input logic [7:0] p, d0, d1);
		tws_master_model_i.m_start;
		wr_ck({DEVICE_BUS_ADDRESS, 1'b0});
		wr_ck(p);
		wr_ck(d0);
		wr_ck(d1);
		tws_master_model_i.m_stop;
	endtask
	task automatic read3(input logic [7:0] p);
		tws_master_model_i.m_start;
		wr_ck({DEVICE_BUS_ADDRESS, 1'b0});
		wr_ck(p);
		tws_master_model_i.m_start;
		wr_ck({DEVICE_BUS_ADDRESS, 1'b1});
		tws_master_model_i.m_rd(1'b1, rd[23:16]);
		tws_master_model_i.m_rd(1'b1, rd[15:8]);
		tws_master_model_i.m_rd(1'b0, rd[7:0]);
		#700;
		check("released", 24'h0, {23'h0, sda_oe});
		check("sda_out", 24'h0, {23'h0, sda_out});
		tws_master_model_i.m_stop;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_probe;
		for (int i = 0; i < 8; i++) begin
			tws_master_model_i.m_start;
			tws_master_model_i.m_wr({DEVICE_BUS_ADDRESS ^ (7'h01 << i),
				1'b0}, ack);
			tws_master_model_i.m_stop;
			check("address ack", {23'h0, i == 7}, {23'h0, ack});
		end
	endtask
	task automatic s_write;
		hw_q.delete();
		write_two(ACC_MSB_ADDR, 8'hA5, 8'h3C);
		check("stores", 24'h2, 24'(hw_q.size()));
		check("store 0", {8'h0, ACC_MSB_ADDR, 8'hA5}, {8'h0, hw_q[0]});
		check("store 1", {8'h0, ACC_LSB_ADDR, 8'h3C}, {8'h0, hw_q[1]});
	endtask
	task automatic s_discard;
		hw_q.delete();
		write_two(ACC_BIAS_ADDR, 8'h11, 8'h22);
		write_two(8'hFD, 8'h33, 8'h44);
		write_two(LAST_WR_ADDR, 8'h55, 8'h66);
		check("kept stores", 24'h1, 24'(hw_q.size()));
		check("kept", {8'h0, ACC_BIAS_ADDR, 8'h11}, {8'h0, hw_q[0]});
	endtask
	task automatic s_partial;
		hw_q.delete();
		tws_master_model_i.m_start;
		wr_ck({DEVICE_BUS_ADDRESS, 1'b0});
		wr_ck(OFS_BIAS_ADDR);
		tws_master_model_i.m_abort(5);
		check("partial stores", 24'h0, 24'(hw_q.size()));
	endtask
	task automatic s_read;
		read3(ACC_MSB_ADDR);
		check("pair read", 24'hA53C, {8'h0, rd[23:8]});
	endtask
	task automatic s_upd;
		upd_write(8'hFF, 8'h5A);
		upd_write(PAIR_FIRST, 8'h12);
		upd_write(PAIR_FIRST + 8'h01, 8'h34);
		tws_master_model_i.half_ns = 2500;
		read3(8'hFF);
		check("over read", 24'h5AFFFF, rd);
		tws_master_model_i.half_ns = 1300;
		fork
			read3(PAIR_FIRST);
			begin
				#85000;
				upd_write(PAIR_FIRST + 8'h01, 8'h77);
			end
		join
		check("latched pair", 24'h1234, {8'h0, rd[23:8]});
		read3(PAIR_FIRST);
		check("updated pair", 24'h1277, {8'h0, rd[23:8]});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		link_clk = 1'b0;
		rst_n = 1'b0;
		upd_valid = 1'b0;
		upd_addr = 8'h00;
		upd_data = 8'h00;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (40) @(negedge clk);
		s_probe;
		s_write;
		s_discard;
		s_partial;
		s_read;
		s_upd;
		tally_and_finish;
	end
endmodule // test_two_wire_register_slave
